//--- src/cfl_lock_fetch_ctrl.sv
// Lock levels, software registers, fetch steering and data EEPROM
// page write for the on-chip code flash.
// Assumes the nonvolatile byte, ports and array answer on core_clk;
// only the access pin is asynchronous.
`timescale 1ns/1ns
`default_nettype none
module cfl_lock_fetch_ctrl
  import cfl_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h11, // Arbitrary value
  parameter logic [7:0] FAMILY_CODE = 8'h22, // Arbitrary value
  parameter logic [7:0] MEMORY_CODE = 8'h33, // Arbitrary value
  parameter logic [7:0] NAME_REV_CODE = 8'h44 // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] nv_hsb,
  input wire logic external_access_pin,
  output logic [7:0] hsb_value,
  output logic [15:0] boot_address,
  output logic [1:0] hw_level,
  output logic [1:0] sw_level,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  output logic fetch_external,
  output logic fetch_blocked,
  input wire logic const_read_valid,
  input wire logic const_read_from_ext,
  input wire logic [15:0] const_read_addr,
  output logic const_read_blocked,
  input wire logic par_req,
  input wire cfl_par_cmd_type par_cmd,
  input wire logic [7:0] par_addr,
  output logic par_done,
  output logic par_refused,
  output logic [7:0] par_rdata,
  output logic flash_erase,
  input wire logic isp_req,
  input wire cfl_isp_cmd_type isp_cmd,
  output logic isp_done,
  output logic isp_refused,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  output logic [7:0] sw_rdata,
  output logic sw_rvalid,
  input wire logic ecr_wr,
  input wire logic [7:0] ecr_wdata,
  output logic [7:0] ecr_rdata,
  input wire logic xd_wr,
  input wire logic xd_rd,
  input wire logic [15:0] xd_addr,
  input wire logic [7:0] xd_wdata,
  output logic xd_ee_select,
  output logic [7:0] xd_rdata,
  output logic xd_rvalid,
  output logic ee_array_rd,
  output logic [EE_ADDR_W-1:0] ee_array_rd_addr,
  input wire logic [7:0] ee_array_rdata,
  output logic ee_array_wr,
  output logic [EE_ADDR_W-1:0] ee_array_wr_addr,
  output logic [7:0] ee_array_wdata
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic ea_meta_reg;
  logic ea_sync_reg;
  logic ea_latched_reg;
  logic load_pend_reg;
  logic [7:0] hsb_reg;
  cfl_level_type level_reg;
  logic [7:0] boot_status_reg;
  logic [7:0] boot_vector_reg;
  logic [7:0] sw_lock_reg;
  cfl_level_type sw_level_now;
  logic ea_effective;
  logic par_allow;
  logic isp_allow;
  logic [7:0] reg_read_mux;
  logic [7:0] par_rdata_reg;
  logic par_done_reg;
  logic par_refused_reg;
  logic flash_erase_reg;
  logic isp_done_reg;
  logic isp_refused_reg;
  logic [7:0] sw_rdata_reg;
  logic sw_rvalid_reg;
  logic [15:0] boot_address_reg;
  logic eee_reg;
  logic busy_reg;
  logic armed_reg;
  cfl_ee_state_type ee_state_reg;
  logic [IDX_W-1:0] scan_idx_reg;
  logic [ROW_W-1:0] page_reg;
  logic page_valid_reg;
  logic ee_hit;
  logic latch_write;
  logic [7:0] xd_rdata_reg;
  logic xd_rvalid_reg;
  logic rd_pend_reg;
  logic rd_busy_reg;
  logic ee_wr_reg;
  logic [EE_ADDR_W-1:0] ee_wr_addr_reg;
  logic [7:0] ee_wdata_reg;

  cfl_latch_if lat();

  cfl_latch_mem u_latch_mem (
    .core_clk(core_clk),
    .reset(reset),
    .lat(lat.mem)
  );

  function automatic cfl_level_type decode_hw(input logic [7:0] hardware_security_byte);
    cfl_level_type lvl;
    lvl = LVL1;
    if (!hardware_security_byte[HSB_LB2_BIT]) begin
      lvl = LVL4;
    end else if (!hardware_security_byte[HSB_LB1_BIT]) begin
      lvl = LVL3;
    end else if (!hardware_security_byte[HSB_LB0_BIT]) begin
      lvl = LVL2;
    end
    return lvl;
  endfunction

  // ----------------------------------------
  // Access pin synchroniser
  // ----------------------------------------
  // No reset: the pin must be tracked while reset is held
  always_ff @(posedge core_clk) begin
    ea_meta_reg <= external_access_pin;
    ea_sync_reg <= ea_meta_reg;
  end

  // ----------------------------------------
  // Security byte and lock level
  // ----------------------------------------
  // Factory value stands until the stored byte is taken after release
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hsb_reg <= HSB_FACTORY; // see (R06) see (R07)
      level_reg <= LVL4; // see (R06)
      load_pend_reg <= 1'b1;
      ea_latched_reg <= 1'b0;
    end else if (load_pend_reg) begin
      hsb_reg <= nv_hsb; // see (R25)
      level_reg <= decode_hw(nv_hsb); // see (R25)
      ea_latched_reg <= ea_sync_reg; // see (R02)
      load_pend_reg <= 1'b0;
    end else if (par_req && par_cmd == PAR_CHIP_ERASE) begin
      hsb_reg <= HSB_ERASED; // see (R08)
      level_reg <= LVL1; // see (R08)
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      boot_address_reg <= LOADER_START;
    end else if (load_pend_reg) begin
      boot_address_reg <= nv_hsb[HSB_BOOT_SEL_BIT] ? APP_START : LOADER_START; // see (R24)
    end
  end

  assign hsb_value = hsb_reg;
  assign hw_level = level_reg;
  assign boot_address = boot_address_reg;

  // ----------------------------------------
  // Fetch steering
  // ----------------------------------------
  // Live pin is ignored once the lock level latches it
  assign ea_effective = (level_reg >= LVL2) ? ea_latched_reg : ea_sync_reg; // see (R02)
  // see (R14) see (R15)
  assign fetch_external = fetch_valid && (!ea_effective || fetch_addr > INTERNAL_TOP);
  assign fetch_blocked = fetch_external && level_reg == LVL4; // see (R05)
  // see (R01)
  assign const_read_blocked = const_read_valid && const_read_from_ext &&
      level_reg >= LVL2 && ea_effective && const_read_addr <= INTERNAL_TOP;

  // ----------------------------------------
  // Software register area
  // ----------------------------------------
  always_comb begin
    case (sw_addr)
      OFS_BOOT_STATUS: reg_read_mux = boot_status_reg;
      OFS_BOOT_VECTOR: reg_read_mux = boot_vector_reg;
      OFS_SW_LOCK: reg_read_mux = sw_lock_reg;
      OFS_MAKER: reg_read_mux = MAKER_CODE;
      OFS_FAMILY: reg_read_mux = FAMILY_CODE;
      OFS_MEMORY: reg_read_mux = MEMORY_CODE;
      OFS_NAME_REV: reg_read_mux = NAME_REV_CODE;
      default: reg_read_mux = 8'h00;
    endcase
  end

  // Bits above the two lock bits are stored as written by software
  always_ff @(posedge core_clk) begin
    if (reset) begin
      boot_status_reg <= SW_REG_RESET;
      boot_vector_reg <= SW_REG_RESET;
      sw_lock_reg <= SW_REG_RESET;
    end else if (sw_wr) begin
      case (sw_addr)
        OFS_BOOT_STATUS: boot_status_reg <= sw_wdata;
        OFS_BOOT_VECTOR: boot_vector_reg <= sw_wdata;
        OFS_SW_LOCK: sw_lock_reg <= sw_wdata; // see (R13)
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sw_rdata_reg <= 8'h00;
      sw_rvalid_reg <= 1'b0;
    end else begin
      sw_rvalid_reg <= sw_rd;
      if (sw_rd) begin
        sw_rdata_reg <= reg_read_mux;
      end
    end
  end

  assign sw_rdata = sw_rdata_reg;
  assign sw_rvalid = sw_rvalid_reg;

  always_comb begin
    sw_level_now = LVL1;
    if (!sw_lock_reg[SSB_LB0_BIT]) begin
      sw_level_now = sw_lock_reg[SSB_LB1_BIT] ? LVL2 : LVL3;
    end
  end

  assign sw_level = sw_level_now;

  // ----------------------------------------
  // Parallel programmer gate
  // ----------------------------------------
  always_comb begin
    case (par_cmd)
      PAR_PROG_FLASH: par_allow = level_reg == LVL1; // see (R03)
      PAR_PROG_EEPROM: par_allow = level_reg == LVL1; // see (R03)
      PAR_VERIFY: par_allow = level_reg <= LVL2; // see (R04)
      PAR_READ_ID: par_allow = 1'b1; // see (R09)
      PAR_CHIP_ERASE: par_allow = 1'b1; // see (R08)
      default: par_allow = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      par_done_reg <= 1'b0;
      par_refused_reg <= 1'b0;
      flash_erase_reg <= 1'b0;
      par_rdata_reg <= 8'h00;
    end else begin
      par_done_reg <= par_req && par_allow;
      par_refused_reg <= par_req && !par_allow;
      flash_erase_reg <= par_req && par_cmd == PAR_CHIP_ERASE; // see (R08)
      if (par_req && par_cmd == PAR_READ_ID) begin
        case (par_addr)
          OFS_MAKER: par_rdata_reg <= MAKER_CODE; // see (R09)
          OFS_FAMILY: par_rdata_reg <= FAMILY_CODE;
          OFS_MEMORY: par_rdata_reg <= MEMORY_CODE;
          OFS_NAME_REV: par_rdata_reg <= NAME_REV_CODE;
          default: par_rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign par_done = par_done_reg;
  assign par_refused = par_refused_reg;
  assign flash_erase = flash_erase_reg;
  assign par_rdata = par_rdata_reg;

  // ----------------------------------------
  // ISP gate
  // ----------------------------------------
  // Hardware lock bits never gate ISP, only the software byte does
  always_comb begin
    case (isp_cmd)
      ISP_PROGRAM: isp_allow = sw_level_now == LVL1; // see (R11)
      ISP_VERIFY: isp_allow = sw_level_now != LVL3; // see (R12)
      default: isp_allow = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      isp_done_reg <= 1'b0;
      isp_refused_reg <= 1'b0;
    end else begin
      isp_done_reg <= isp_req && isp_allow;
      isp_refused_reg <= isp_req && !isp_allow;
    end
  end

  assign isp_done = isp_done_reg;
  assign isp_refused = isp_refused_reg;

  // ----------------------------------------
  // EEPROM control register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eee_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (ecr_wr) begin
      eee_reg <= ecr_wdata[ECR_ENABLE_BIT]; // see (R17)
      armed_reg <= ecr_wdata == LAUNCH_FIRST; // see (R22)
    end
  end

  assign ecr_rdata = {6'h00, eee_reg, busy_reg};

  // ----------------------------------------
  // Data space decode and latch loading
  // ----------------------------------------
  assign ee_hit = eee_reg && xd_addr <= EE_TOP; // see (R17)
  assign xd_ee_select = ee_hit && (xd_wr || xd_rd);
  // Other-page bytes are dropped so the first page stays latched
  assign latch_write = xd_wr && ee_hit && !busy_reg &&
      (!page_valid_reg || xd_addr[EE_ADDR_W-1:IDX_W] == page_reg); // see (R23)

  assign lat.wr_en = latch_write; // see (R19)
  assign lat.wr_idx = xd_addr[IDX_W-1:0]; // see (R23)
  assign lat.wr_data = xd_wdata;
  assign lat.rd_idx = scan_idx_reg;
  assign lat.clear_all = ee_state_reg == EE_CLEAR; // see (R21)

  always_ff @(posedge core_clk) begin
    if (reset) begin
      page_reg <= '0;
      page_valid_reg <= 1'b0;
    end else if (ee_state_reg == EE_CLEAR) begin
      page_valid_reg <= 1'b0;
    end else if (latch_write && !page_valid_reg) begin
      page_reg <= xd_addr[EE_ADDR_W-1:IDX_W]; // see (R23)
      page_valid_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Row programming
  // ----------------------------------------
  // Each byte costs a read and a write cycle; the scan is 256 cycles
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ee_state_reg <= EE_IDLE;
      busy_reg <= 1'b0;
      scan_idx_reg <= '0;
    end else begin
      case (ee_state_reg)
        EE_IDLE: begin
          if (ecr_wr && ecr_wdata == LAUNCH_SECOND && armed_reg) begin
            busy_reg <= 1'b1; // see (R22)
            scan_idx_reg <= '0;
            ee_state_reg <= EE_READ; // see (R19)
          end
        end
        EE_READ: ee_state_reg <= EE_WRITE;
        EE_WRITE: begin
          if (scan_idx_reg == IDX_LAST) begin
            ee_state_reg <= EE_CLEAR;
          end else begin
            scan_idx_reg <= scan_idx_reg + 1'b1;
            ee_state_reg <= EE_READ;
          end
        end
        EE_CLEAR: begin
          busy_reg <= 1'b0; // see (R22)
          ee_state_reg <= EE_IDLE;
        end
        default: ee_state_reg <= EE_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ee_wr_reg <= 1'b0;
      ee_wr_addr_reg <= '0;
      ee_wdata_reg <= 8'h00;
    end else begin
      ee_wr_reg <= ee_state_reg == EE_WRITE && lat.rd_flag; // see (R20)
      ee_wr_addr_reg <= {page_reg, scan_idx_reg};
      ee_wdata_reg <= lat.rd_data;
    end
  end

  assign ee_array_wr = ee_wr_reg;
  assign ee_array_wr_addr = ee_wr_addr_reg;
  assign ee_array_wdata = ee_wdata_reg;

  // ----------------------------------------
  // EEPROM reads
  // ----------------------------------------
  // Array is not readable while a row is programming
  assign ee_array_rd = xd_rd && ee_hit && !busy_reg; // see (R18)
  assign ee_array_rd_addr = xd_addr[EE_ADDR_W-1:0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_pend_reg <= 1'b0;
      rd_busy_reg <= 1'b0;
      xd_rvalid_reg <= 1'b0;
      xd_rdata_reg <= 8'h00;
    end else begin
      rd_pend_reg <= xd_rd && ee_hit;
      rd_busy_reg <= busy_reg;
      xd_rvalid_reg <= rd_pend_reg;
      if (rd_pend_reg) begin
        xd_rdata_reg <= rd_busy_reg ? EE_BUSY_READ : ee_array_rdata; // see (R18)
      end
    end
  end

  assign xd_rdata = xd_rdata_reg;
  assign xd_rvalid = xd_rvalid_reg;

endmodule
`default_nettype wire

//--- src/cfl_pkg.sv
// Constants and types of the code flash lock and fetch control block.
// Assumes a single core clock domain and a synchronous active-high reset.
// How it works
// (R01) Level 2: external constant reads see no internal byte
// (R02) Level 2 up: access pin latched at reset
// (R03) Level 2: parallel programming refused, ISP allowed
// (R04) Level 3: also parallel verify refused
// (R05) Level 4: also external execution refused
// (R06) Factory lock level is 4
// (R07) Factory byte: loader boot, standard speed, 32 MHz
// (R08) Chip erase clears flash and security byte
// (R09) Part identification always readable in parallel
// (R10) ISP software clears boot status after programming
// (R11) Software level 2 refuses ISP programming
// (R12) Software level 3 also refuses ISP verify
// (R13) Software keeps software lock bits 7..2 high
// (R14) Access pin high: internal up to 7FFFh
// (R15) Access pin low: every fetch external
// (R16) Application leaves last internal location unused
// (R17) Data EEPROM mapped 0000h-03FFh only when enabled
// (R18) Mapped data moves read the EEPROM
// (R19) Write: load latches, then program one row
// (R20) 1 to 128 bytes, only flagged bytes programmed
// (R21) Latch write sets flag, row end clears all
// (R22) 52h then A2h launches; busy until done
// (R23) Upper 4 bits row, lower 7 byte
// (R24) Boot select picks 0000h or F400h start
// (R25) Lock level read at reset, held stable
package cfl_pkg;

  // ----------------------------------------
  // Software register area
  // ----------------------------------------
  localparam logic [7:0] OFS_BOOT_STATUS = 8'h00;
  localparam logic [7:0] OFS_BOOT_VECTOR = 8'h01;
  localparam logic [7:0] OFS_SW_LOCK = 8'h05;
  localparam logic [7:0] OFS_MAKER = 8'h30;
  localparam logic [7:0] OFS_FAMILY = 8'h31;
  localparam logic [7:0] OFS_MEMORY = 8'h60;
  localparam logic [7:0] OFS_NAME_REV = 8'h61;
  localparam logic [7:0] SW_REG_RESET = 8'hFF;

  // ----------------------------------------
  // Hardware security byte
  // ----------------------------------------
  localparam int HSB_SPEED_BIT = 7;
  localparam int HSB_BOOT_SEL_BIT = 6;
  localparam int HSB_LB2_BIT = 2;
  localparam int HSB_LB1_BIT = 1;
  localparam int HSB_LB0_BIT = 0;
  localparam int SSB_LB1_BIT = 1;
  localparam int SSB_LB0_BIT = 0;
  // Speed 1, loader boot 0, oscillator 11, reserved 1, lock 011
  localparam logic [7:0] HSB_FACTORY = 8'hBB;
  localparam logic [7:0] HSB_ERASED = 8'hFF;

  // ----------------------------------------
  // Program memory map
  // ----------------------------------------
  localparam logic [15:0] INTERNAL_TOP = 16'h7FFF;
  localparam logic [15:0] APP_START = 16'h0000;
  localparam logic [15:0] LOADER_START = 16'hF400;

  // ----------------------------------------
  // Data EEPROM
  // ----------------------------------------
  localparam logic [15:0] EE_TOP = 16'h03FF;
  localparam int IDX_W = 7;
  localparam int ROW_W = 4;
  localparam int EE_ADDR_W = 11;
  localparam int PAGE_BYTES = 128;
  localparam logic [IDX_W-1:0] IDX_LAST = 7'h7F;
  localparam logic [7:0] LAUNCH_FIRST = 8'h52;
  localparam logic [7:0] LAUNCH_SECOND = 8'hA2;
  localparam int ECR_ENABLE_BIT = 1;
  localparam int ECR_BUSY_BIT = 0;
  localparam logic [7:0] EE_BUSY_READ = 8'hFF;

  typedef enum logic [1:0] {LVL1, LVL2, LVL3, LVL4} cfl_level_type;
  typedef enum logic [2:0] {
    PAR_PROG_FLASH, PAR_PROG_EEPROM, PAR_VERIFY, PAR_READ_ID, PAR_CHIP_ERASE
  } cfl_par_cmd_type;
  typedef enum logic {ISP_PROGRAM, ISP_VERIFY} cfl_isp_cmd_type;
  typedef enum logic [1:0] {EE_IDLE, EE_READ, EE_WRITE, EE_CLEAR} cfl_ee_state_type;

endpackage

//--- src/cfl_latch_if.sv
// Column latch access between the controller and the latch memory.
// Assumes both ends share core_clk.
`timescale 1ns/1ns
`default_nettype none
interface cfl_latch_if import cfl_pkg::*; ;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_flag;
  logic clear_all;
  modport ctrl(output wr_en, wr_idx, wr_data, rd_idx, clear_all, input rd_data, rd_flag);
  modport mem(input wr_en, wr_idx, wr_data, rd_idx, clear_all, output rd_data, rd_flag);
endinterface
`default_nettype wire

//--- src/cfl_latch_mem.sv
// Column latches of one EEPROM page with a written flag per byte.
// Assumes writes and clear never coincide; read data are registered.
`timescale 1ns/1ns
`default_nettype none
module cfl_latch_mem
  import cfl_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  cfl_latch_if.mem lat
);

  logic [7:0] data_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] flag_reg;

  always_ff @(posedge core_clk) begin
    if (lat.wr_en) begin
      data_mem[lat.wr_idx] <= lat.wr_data;
    end
  end

  // ----------------------------------------
  // Ninth bits
  // ----------------------------------------
  for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_flag
    always_ff @(posedge core_clk) begin
      if (reset) begin
        flag_reg[i] <= 1'b0;
      end else if (lat.wr_en && lat.wr_idx == IDX_W'(i)) begin
        flag_reg[i] <= 1'b1; // see (R21)
      end else if (lat.clear_all) begin
        flag_reg[i] <= 1'b0; // see (R21)
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lat.rd_data <= 8'h00;
      lat.rd_flag <= 1'b0;
    end else begin
      lat.rd_data <= data_mem[lat.rd_idx];
      lat.rd_flag <= flag_reg[lat.rd_idx];
    end
  end

endmodule
`default_nettype wire

//--- tb/cfl_ee_model.sv
// Data EEPROM array model on the far side of the page write.
// Assumes read data are wanted one cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module cfl_ee_model (
  input wire logic core_clk,
  input wire logic rd,
  input wire logic [10:0] rd_addr,
  output logic [7:0] rdata,
  input wire logic wr,
  input wire logic [10:0] wr_addr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [0:2047];
  int n_wr = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  always @(posedge core_clk) begin
    // Outside a read the bus toggles, so stale data never passes
    rdata <= rd ? mem[rd_addr] : ~rdata;
    if (wr) begin
      mem[wr_addr] <= wdata;
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/cfl_lock_fetch_checker.sv
// Properties of the lock and fetch control top, seen at its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module cfl_lock_fetch_checker
  import cfl_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] hsb_value,
  input wire logic [1:0] hw_level,
  input wire logic [1:0] sw_level,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_external,
  input wire logic fetch_blocked,
  input wire logic par_req,
  input wire cfl_par_cmd_type par_cmd,
  input wire logic par_done,
  input wire logic par_refused,
  input wire logic flash_erase,
  input wire logic isp_req,
  input wire cfl_isp_cmd_type isp_cmd,
  input wire logic isp_refused,
  input wire logic [7:0] ecr_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_par_prog_lock: assert property (
    par_req && par_cmd == PAR_PROG_FLASH && hw_level != 2'h0 |=> par_refused && !par_done)
    else $error("program accepted while locked");
  a_par_verify_lock: assert property (
    par_req && par_cmd == PAR_VERIFY && hw_level >= 2'h2 |=> par_refused)
    else $error("verify accepted while locked");
  a_ext_exec_lock: assert property (
    fetch_valid && hw_level == 2'h3 |-> fetch_blocked == fetch_external)
    else $error("external fetch not blocked");
  a_id_readable: assert property (
    par_req && par_cmd == PAR_READ_ID |=> par_done && !par_refused)
    else $error("id read refused");
  a_erase_clears: assert property (
    par_req && par_cmd == PAR_CHIP_ERASE |=> flash_erase && hsb_value == 8'hFF && hw_level == 2'h0)
    else $error("erase left lock set");
  a_isp_prog_lock: assert property (
    isp_req && isp_cmd == ISP_PROGRAM && sw_level != 2'h0 |=> isp_refused)
    else $error("isp program accepted");
  a_high_fetch_ext: assert property (
    fetch_valid && fetch_addr > 16'h7FFF |-> fetch_external)
    else $error("high fetch kept internal");
  a_busy_holds: assert property (
    $rose(ecr_rdata[0]) |-> ecr_rdata[0] [*8])
    else $error("busy dropped early");
  c_erase: cover property (par_req && par_cmd == PAR_CHIP_ERASE);
  c_busy_end: cover property ($fell(ecr_rdata[0]));
  c_ext_block: cover property (fetch_blocked);
endmodule
bind cfl_lock_fetch_ctrl cfl_lock_fetch_checker chk_u (.*);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for lock levels, fetch steering and EEPROM page write.
// Assumes the EEPROM array model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cfl_pkg::*;
  logic core_clk = 0, reset = 1, external_access_pin = 1;
  logic fetch_valid = 0, const_read_valid = 0, const_read_from_ext = 0;
  logic par_req = 0, isp_req = 0, sw_wr = 0, sw_rd = 0, ecr_wr = 0, xd_wr = 0, xd_rd = 0;
  logic [7:0] nv_hsb = 8'hBB, par_addr = 0, sw_addr = 0, sw_wdata = 0, ecr_wdata = 0;
  logic [7:0] xd_wdata = 0, hsb_value, par_rdata, sw_rdata, ecr_rdata, xd_rdata;
  logic [7:0] ee_array_rdata, ee_array_wdata;
  logic [15:0] fetch_addr = 0, const_read_addr = 0, xd_addr = 0, boot_address;
  logic [1:0] hw_level, sw_level;
  logic fetch_external, fetch_blocked, const_read_blocked, par_done, par_refused;
  logic flash_erase, isp_done, isp_refused, sw_rvalid, xd_ee_select, xd_rvalid;
  logic ee_array_rd, ee_array_wr;
  logic [EE_ADDR_W-1:0] ee_array_rd_addr, ee_array_wr_addr;
  cfl_par_cmd_type par_cmd = PAR_READ_ID;
  cfl_isp_cmd_type isp_cmd = ISP_PROGRAM;
  int n_fail = 0, compares = 0, ticks = 0;
  cfl_lock_fetch_ctrl dut_u (.*);
  cfl_ee_model ee_u (.core_clk(core_clk), .rd(ee_array_rd), .rd_addr(ee_array_rd_addr),
    .rdata(ee_array_rdata), .wr(ee_array_wr), .wr_addr(ee_array_wr_addr),
    .wdata(ee_array_wdata));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rst(input logic [7:0] h, input logic p);
    reset = 1;
    nv_hsb = h;
    external_access_pin = p;
    cyc(2);
    chk(hsb_value, 8'hBB);
    chk(hw_level, 2'h3);
    reset = 0;
    cyc(2);
  endtask
  task automatic par(input cfl_par_cmd_type c, input logic [7:0] a, input logic ok);
    par_req = 1;
    par_cmd = c;
    par_addr = a;
    cyc(1);
    par_req = 0;
    chk(par_done, ok);
    chk(par_refused, !ok);
    #1;
  endtask
  task automatic isp(input cfl_isp_cmd_type c, input logic ok);
    isp_req = 1;
    isp_cmd = c;
    cyc(1);
    isp_req = 0;
    chk(isp_done, ok);
    chk(isp_refused, !ok);
    #1;
  endtask
  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    sw_wr = 1;
    sw_addr = a;
    sw_wdata = d;
    cyc(1);
    sw_wr = 0;
    #1;
  endtask
  task automatic swq(input logic [7:0] a, input logic [7:0] e);
    sw_rd = 1;
    sw_addr = a;
    cyc(1);
    sw_rd = 0;
    chk(sw_rvalid, 1);
    chk(sw_rdata, e);
    #1;
  endtask
  task automatic ecw(input logic [7:0] d);
    ecr_wr = 1;
    ecr_wdata = d;
    cyc(1);
    ecr_wr = 0;
    #1;
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    xd_wr = 1;
    xd_addr = a;
    xd_wdata = d;
    cyc(1);
    xd_wr = 0;
    #1;
  endtask
  task automatic xr(input logic [15:0] a, input logic s, input logic [7:0] e);
    xd_rd = 1;
    xd_addr = a;
    #2;
    chk(xd_ee_select, s);
    cyc(1);
    xd_rd = 0;
    cyc(1);
    chk(xd_rvalid, s);
    if (s) chk(xd_rdata, e);
  endtask
  task automatic fe(input logic [15:0] a, input logic x, input logic b);
    fetch_valid = 1;
    fetch_addr = a;
    #1;
    chk(fetch_external, x);
    chk(fetch_blocked, b);
  endtask
  task automatic cr(input logic [15:0] a, input logic x, input logic b);
    const_read_valid = 1;
    const_read_from_ext = x;
    const_read_addr = a;
    #1;
    chk(const_read_blocked, b);
  endtask
  task automatic prog(input int n);
    int k;
    k = 0;
    ecw(8'h52);
    ecw(8'hA2);
    chk(ecr_rdata[0], 1);
    while (ecr_rdata[0] === 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    chk(k, 257);
    chk(ee_u.n_wr, n);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_factory();
    logic [7:0] ida [4] = '{8'h30, 8'h31, 8'h60, 8'h61};
    logic [7:0] idv [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    rst(8'hBB, 1);
    chk(hw_level, 2'h3);
    chk(boot_address, 16'hF400);
    swq(8'h00, 8'hFF);
    swq(8'h01, 8'hFF);
    swq(8'h05, 8'hFF);
    swq(8'h07, 8'h00);
    swr(8'h30, 8'h00);
    foreach (ida[i]) begin
      swq(ida[i], idv[i]);
      par(PAR_READ_ID, ida[i], 1);
      chk(par_rdata, idv[i]);
    end
    fe(16'h0100, 0, 0);
    fe(16'h7FFE, 0, 0);
    fe(16'h8000, 1, 1);
    par(PAR_PROG_FLASH, 8'h00, 0);
    par(PAR_VERIFY, 8'h00, 0);
    par(PAR_CHIP_ERASE, 8'h00, 1);
    chk(flash_erase, 1);
    par(PAR_PROG_EEPROM, 8'h00, 1);
    cr(16'h0100, 1, 0);
    $display("done t_factory");
  endtask
  task automatic t_locks();
    rst(8'hFE, 1);
    chk(hw_level, 2'h1);
    chk(boot_address, 16'h0000);
    cr(16'h0100, 1, 1);
    cr(16'h8000, 1, 0);
    cr(16'h0100, 0, 0);
    par(PAR_PROG_EEPROM, 8'h00, 0);
    par(PAR_VERIFY, 8'h00, 1);
    isp(ISP_PROGRAM, 1);
    external_access_pin = 0;
    cyc(4);
    fe(16'h0100, 0, 0);
    rst(8'hFD, 1);
    par(PAR_VERIFY, 8'h00, 0);
    fe(16'h8000, 1, 0);
    rst(8'hFF, 0);
    fe(16'h0100, 1, 0);
    $display("done t_locks");
  endtask
  task automatic t_sw();
    swr(8'h00, 8'h00);
    swq(8'h00, 8'h00);
    swr(8'h05, 8'hFE);
    chk(sw_level, 2'h1);
    isp(ISP_PROGRAM, 0);
    isp(ISP_VERIFY, 1);
    swr(8'h05, 8'hFC);
    isp(ISP_VERIFY, 0);
    swr(8'h05, 8'hFF);
    isp(ISP_PROGRAM, 1);
    $display("done t_sw");
  endtask
  task automatic t_ee();
    ecw(8'h00);
    xr(16'h03FF, 0, 8'h00);
    ecw(8'h02);
    xr(16'h0400, 0, 8'h00);
    xw(16'h0105, 8'hA5);
    xw(16'h0106, 8'h5A);
    xw(16'h0000, 8'h77);
    prog(2);
    chk(ee_u.mem[11'h106], 8'h5A);
    chk(ee_u.mem[11'h000], 8'hFF);
    xr(16'h0105, 1, 8'hA5);
    xw(16'h0000, 8'h77);
    prog(3);
    xr(16'h0000, 1, 8'h77);
    $display("done t_ee");
  endtask
  initial begin
    t_factory();
    t_locks();
    t_sw();
    t_ee();
    close_out();
  end
endmodule
`default_nettype wire
